// file: rtl/tlic_ctrl.sv
// Two-level interrupt priority controller, top level.
// Assumes source events are one-cycle pulses on clk and the core answers
// with one-cycle accept and return pulses; only the external pin is async.
`timescale 1ns/1ns
`include "tlic_params.svh"

module tlic_ctrl #(
    parameter int NCORE = `TLIC_CORE_SRC,
    parameter int NPERIPH = `TLIC_GROUP_REGS * `TLIC_BITS_PER_REG,
    parameter int NSRC = NCORE + NPERIPH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ext_external_interrupt_zero_pin,
    input wire logic ext_external_interrupt_zero_rising,
    input wire logic [NSRC-1:0] src_event,
    input wire logic [NSRC-1:0] src_flag_clr,
    input wire logic [NSRC-1:0] src_enable,
    input wire logic [NSRC-1:0] src_priority,
    input wire logic glob_wr,
    input wire tlic_pkg::tlic_glob_s glob_wdata,
    input wire logic prio_wr,
    input wire logic prio_wdata,
    input wire logic core_accept,
    input wire logic core_return,
    output logic [NSRC-1:0] src_flag,
    output tlic_pkg::tlic_glob_s glob_en,
    output logic priority_levels_enable,
    output tlic_pkg::tlic_vec_s irq_out,
    output tlic_pkg::tlic_svc_e svc_state
);
    import tlic_pkg::*;

    // ****************************************************************
    // Source layout
    // ****************************************************************
    // Core sources sit below the five request groups of peripherals
    // Control trio, then flag, enable and priority groups, then the mode register
    localparam int NREGS = `TLIC_CTRL_REGS + 3 * `TLIC_GROUP_REGS + 1;
    localparam logic [NSRC-1:0] PERIPH_MASK = {{NPERIPH{1'b1}}, {NCORE{1'b0}}};
    localparam logic [NSRC-1:0] EXT0_MASK = NSRC'(1) << `TLIC_EXT0_BIT;
    localparam logic [15:0] VEC_HIGH = `TLIC_VEC_HIGH;
    localparam logic [15:0] VEC_LOW = `TLIC_VEC_LOW;

    // ****************************************************************
    // External interrupt zero pin
    // ****************************************************************
    logic ext_meta_reg;         // First synchroniser stage
    logic ext_sync_reg;         // Second synchroniser stage
    logic ext_prev_reg;         // Delayed copy for edge detect
    logic [2:0] ext_arm_reg;    // Fills with ones as the chain loads
    wire ext_rise = ext_sync_reg & ~ext_prev_reg;
    wire ext_fall = ~ext_sync_reg & ext_prev_reg;
    // No edge until the delayed copy holds a real pin sample,
    // so a pin idling high cannot fake an edge after reset
    wire ext_edge = ext_arm_reg[2] & (ext_external_interrupt_zero_rising ? ext_rise : ext_fall);

    // Pin crosses from outside; only the second stage is examined
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
            ext_arm_reg <= 3'h0;
        end else begin
            ext_meta_reg <= ext_external_interrupt_zero_pin;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
            ext_arm_reg <= {ext_arm_reg[1:0], 1'b1};
        end
    end

    // ****************************************************************
    // Request flags
    // ****************************************************************
    wire [NSRC-1:0] flag_set = src_event | (ext_edge ? EXT0_MASK : '0);

    // Sticky flags live in their own bank
    tlic_flag_bank #(
        .NSRC(NSRC)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set_pulse(flag_set),
        .clr_pulse(src_flag_clr),
        .flag_q(src_flag)
    );

    // ****************************************************************
    // Mode and global enables
    // ****************************************************************
    logic prio_reg;             // Priority levels enable
    tlic_glob_s glob_reg;       // Global enable pair
    tlic_glob_s glob_next;
    tlic_svc_e svc_reg;         // Service nesting
    tlic_svc_e svc_next;
    tlic_vec_s vec_reg;         // Registered request to the core
    tlic_vec_s vec_next;

    wire g_hi = glob_reg.global_or_high_enable;
    wire g_lo = glob_reg.peripheral_or_low_enable;

    // Mode register, cleared by every reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prio_reg <= `TLIC_PRIO_EN_RST;
        end else if (prio_wr) begin
            prio_reg <= prio_wdata;
        end
    end

    // ****************************************************************
    // Pending request decode
    // ****************************************************************
    // Individual enable gates each flag before any global term
    wire [NSRC-1:0] active = src_flag & src_enable;
    // Source zero has no priority bit and counts as high
    wire [NSRC-1:0] hi_sel = src_priority | EXT0_MASK;
    // Compat ignores priority bits entirely
    wire act_core = |(active & ~PERIPH_MASK);
    wire act_periph = |(active & PERIPH_MASK);
    // Peripherals need both enables, core sources only global
    wire compat_pend = g_hi & (act_core | (g_lo & act_periph));
    wire act_hi = |(active & hi_sel);
    wire act_lo = |(active & ~hi_sel);
    // High enable alone passes high sources; clear blocks all
    wire prio_hi_pend = g_hi & act_hi;
    // Low sources need both enables and no service of either level running
    wire prio_lo_pend = g_hi & g_lo & act_lo & (svc_reg == TLIC_SV_IDLE);
    wire hi_pend = prio_reg ? prio_hi_pend : compat_pend;
    wire lo_pend = prio_reg & prio_lo_pend;
    // An accept is only meaningful while a request is shown
    wire take = core_accept & vec_reg.req;
    wire take_hi = take & vec_reg.high;
    wire take_lo = take & ~vec_reg.high;

    // ****************************************************************
    // Vector selection
    // ****************************************************************
    // Request is offered next cycle; the accept cycle withdraws it
    // because take forces vec_next to zero at that same edge
    always_comb begin
        vec_next = '0;
        if (!take && (hi_pend || lo_pend)) begin
            vec_next.req = 1'b1;
            // High wins a tie; compat always reports high
            vec_next.high = hi_pend;
            vec_next.vector = hi_pend ? VEC_HIGH : VEC_LOW;
        end
    end

    // Request register to the core
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vec_reg <= '0;
        end else begin
            vec_reg <= vec_next;
        end
    end

    // ****************************************************************
    // Service nesting and global enable updates
    // ****************************************************************
    // Hardware accept overrides a software write in the same cycle,
    // otherwise a nested request could slip in before the handler runs
    always_comb begin
        glob_next = glob_reg;
        svc_next = svc_reg;
        if (glob_wr) begin
            glob_next = glob_wdata;
        end
        if (core_return) begin
            // Return re-opens the level that was being served
            unique case (svc_reg)
                TLIC_SV_IDLE: begin
                    glob_next.global_or_high_enable = 1'b1;
                end
                TLIC_SV_HIGH: begin
                    glob_next.global_or_high_enable = 1'b1;
                    svc_next = TLIC_SV_IDLE;
                end
                TLIC_SV_NEST: begin
                    glob_next.global_or_high_enable = 1'b1;
                    svc_next = TLIC_SV_LOW;
                end
                TLIC_SV_LOW: begin
                    glob_next.peripheral_or_low_enable = 1'b1;
                    svc_next = TLIC_SV_IDLE;
                end
            endcase
        end
        if (take_hi) begin
            // High accept, possibly nesting over low
            glob_next.global_or_high_enable = 1'b0;
            svc_next = (svc_reg == TLIC_SV_LOW) ? TLIC_SV_NEST : TLIC_SV_HIGH;
        end else if (take_lo) begin
            // Low accept blocks only the low level
            glob_next.peripheral_or_low_enable = 1'b0;
            svc_next = TLIC_SV_LOW;
        end
    end

    // Global enables and nesting state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            glob_reg <= `TLIC_GLOB_RST;
            svc_reg <= TLIC_SV_IDLE;
        end else begin
            glob_reg <= glob_next;
            svc_reg <= svc_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign glob_en = glob_reg;
    assign priority_levels_enable = prio_reg;
    assign irq_out = vec_reg;
    assign svc_state = svc_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_EXT0_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        (prio_reg && active[0] && g_hi && !take && !prio_wr)
        |=> (vec_reg.req && vec_reg.vector == VEC_HIGH))
        else $error("source zero not vectored high");

    AST_COMPAT_VEC: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(!prio_reg) && vec_reg.req) |-> (vec_reg.vector == VEC_HIGH))
        else $error("compat request not at high vector");

    AST_HIGH_BLOCKS_ALL: assert property (@(posedge clk) disable iff (!rst_n)
        !g_hi |=> !vec_reg.req)
        else $error("request while high or global enable clear");

    AST_LOW_NEEDS_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
        (vec_reg.req && !vec_reg.high) |-> $past(g_hi && g_lo && prio_reg))
        else $error("low request without both enables");

    AST_PERIPH_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        (!prio_reg && !g_lo && !act_core) |=> !vec_reg.req)
        else $error("peripheral passed without peripheral enable");

    AST_ENABLE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        (active == '0) |=> !vec_reg.req)
        else $error("request without enabled flag");

    AST_ACCEPT_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        (take_hi |=> !g_hi) and (take_lo |=> !g_lo))
        else $error("accept did not clear global enable");

    AST_RETURN_SETS: assert property (@(posedge clk) disable iff (!rst_n)
        (core_return && !take && svc_reg == TLIC_SV_LOW)
        |=> (g_lo && svc_reg == TLIC_SV_IDLE))
        else $error("return did not reopen low level");

    AST_NO_LOW_IN_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        (svc_reg == TLIC_SV_HIGH || svc_reg == TLIC_SV_NEST)
        |=> !(vec_reg.req && !vec_reg.high))
        else $error("low request during high service");

    AST_PREEMPT: assert property (@(posedge clk) disable iff (!rst_n)
        (prio_reg && svc_reg == TLIC_SV_LOW && g_hi && act_hi && !take && !prio_wr
            && !core_return)
        ##1 (core_accept && !core_return) |=> (svc_reg == TLIC_SV_NEST))
        else $error("high did not preempt low service");

    AST_TIE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        (hi_pend && lo_pend && !take) |=> (vec_reg.high && vec_reg.vector == VEC_HIGH))
        else $error("tie not resolved to high");

    AST_REG_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        NREGS == `TLIC_REG_COUNT)
        else $error("register grouping does not add up");

    AST_RESET_MODE: assert property (@(posedge clk)
        !rst_n |=> !prio_reg)
        else $error("priority enable not cleared by reset");

    COV_COMPAT_TAKE: cover property (@(posedge clk) disable iff (!rst_n)
        !prio_reg && take);
    COV_LOW_TAKE: cover property (@(posedge clk) disable iff (!rst_n)
        prio_reg && take_lo);
    COV_NEST: cover property (@(posedge clk) disable iff (!rst_n)
        svc_reg == TLIC_SV_NEST ##[1:50] core_return);

endmodule : tlic_ctrl

// file: rtl/tlic_flag_bank.sv
// Sticky request flags, one per source.
// Assumes events and clears come from logic on the same clock.
`timescale 1ns/1ns
`include "tlic_params.svh"

module tlic_flag_bank #(
    parameter int NSRC = 48
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NSRC-1:0] set_pulse,
    input wire logic [NSRC-1:0] clr_pulse,
    output logic [NSRC-1:0] flag_q
);
    import tlic_pkg::*;

    // ****************************************************************
    // One sticky cell per source
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < NSRC; i++) begin : g_flag
            logic flag_reg;     // Sticky flag
            logic flag_next;    // Its next value
            // Set wins so an event in the clearing cycle is kept
            assign flag_next = set_pulse[i] | (flag_reg & ~clr_pulse[i]);
            // Flag register, set regardless of any enable
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    flag_reg <= `TLIC_FLAG_RST;
                end else begin
                    flag_reg <= flag_next;
                end
            end
            assign flag_q[i] = flag_reg;
        end
    endgenerate

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (set_pulse != '0) |=> ((flag_q & $past(set_pulse)) == $past(set_pulse)))
        else $error("event did not set its flag");

endmodule : tlic_flag_bank

// file: rtl/tlic_params.svh
// Constants of the two-level interrupt priority controller.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef TLIC_PARAMS_SVH
`define TLIC_PARAMS_SVH

// ****************************************************************
// Vector addresses
// ****************************************************************
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_VEC_W 16

// ****************************************************************
// Register grouping of the sources
// ****************************************************************
`define TLIC_CTRL_REGS 3
`define TLIC_GROUP_REGS 5
`define TLIC_REG_COUNT 19
`define TLIC_BITS_PER_REG 8
`define TLIC_CORE_SRC 8

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define TLIC_EXT0_BIT 0
`define TLIC_PRIO_EN_RST 1'b0
`define TLIC_GLOB_RST 2'b00
`define TLIC_FLAG_RST 1'b0

`endif

// file: rtl/tlic_pkg.sv
// Types shared by the interrupt controller modules.
// Assumes tlic_params.svh is on the include path.
package tlic_pkg;

    // ****************************************************************
    // Global enable pair
    // ****************************************************************
    typedef struct packed {
        logic global_or_high_enable;    // Global, or high level when prioritised
        logic peripheral_or_low_enable; // Peripheral, or low level when prioritised
    } tlic_glob_s;

    // ****************************************************************
    // Vector request towards the core
    // ****************************************************************
    typedef struct packed {
        logic req;                      // Request pending
        logic high;                     // Request is high level
        logic [15:0] vector;            // Vector address
    } tlic_vec_s;

    // Service nesting of the core
    typedef enum logic [1:0] {
        TLIC_SV_IDLE,
        TLIC_SV_LOW,
        TLIC_SV_HIGH,
        TLIC_SV_NEST
    } tlic_svc_e;

endpackage : tlic_pkg

// file: tb/tb_tlic_ctrl.sv
// Self-checking bench of the two-level interrupt priority controller.
// Assumes the core model answers requests; bench drives at the falling edge.
`timescale 1ns/1ns
`include "tlic_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end

module tb_tlic_ctrl;
    import tlic_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext_external_interrupt_zero_pin = 1'b0;
    logic ext_external_interrupt_zero_rising = 1'b1; // Edge select, rising while set
    logic [47:0] src_event = '0;
    logic [47:0] src_flag_clr = '0;
    logic [47:0] src_enable = '0;
    logic [47:0] src_priority = '0;
    logic glob_wr = 1'b0;
    tlic_glob_s glob_wdata = '0;
    logic prio_wr = 1'b0;
    logic prio_wdata = 1'b0;
    logic core_accept;
    logic core_return = 1'b0;
    logic [47:0] src_flag;
    tlic_glob_s glob_en;
    logic priority_levels_enable;
    tlic_vec_s irq_out;
    tlic_svc_e svc_state;
    logic acc_en = 1'b1; // Model answers while set
    logic [3:0] acc_delay = 4'h0; // Zero for prompt, larger for slow
    logic [15:0] last_vec;
    logic last_high;
    int n_acc;
    int n_fail = 0;
    int n_tests = 0;
    int snap; // Accept count before a wait

    tlic_ctrl dut (.clk(clk), .rst_n(rst_n), .ext_external_interrupt_zero_pin(ext_external_interrupt_zero_pin),
        .ext_external_interrupt_zero_rising(ext_external_interrupt_zero_rising), .src_event(src_event), .src_flag_clr(src_flag_clr),
        .src_enable(src_enable), .src_priority(src_priority), .glob_wr(glob_wr),
        .glob_wdata(glob_wdata), .prio_wr(prio_wr), .prio_wdata(prio_wdata),
        .core_accept(core_accept), .core_return(core_return), .src_flag(src_flag),
        .glob_en(glob_en), .priority_levels_enable(priority_levels_enable),
        .irq_out(irq_out), .svc_state(svc_state));

    tlic_core_model core (.clk(clk), .rst_n(rst_n), .irq_out(irq_out), .acc_en(acc_en),
        .acc_delay(acc_delay), .core_accept(core_accept), .last_vec(last_vec),
        .last_high(last_high), .n_acc(n_acc));

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // ****************************************************************
    // Access tasks, one-cycle pulses launched at the falling edge
    // ****************************************************************
    task automatic ev(input logic [47:0] m);
        @(negedge clk) src_event = m;
        @(negedge clk) src_event = '0;
    endtask : ev

    task automatic clr(input logic [47:0] m);
        @(negedge clk) src_flag_clr = m;
        @(negedge clk) src_flag_clr = '0;
    endtask : clr

    task automatic gw(input logic [1:0] v);
        @(negedge clk) begin
            glob_wr = 1'b1;
            glob_wdata = v;
        end
        @(negedge clk) glob_wr = 1'b0;
    endtask : gw

    task automatic pw(input logic v);
        @(negedge clk) begin
            prio_wr = 1'b1;
            prio_wdata = v;
        end
        @(negedge clk) prio_wr = 1'b0;
    endtask : pw

    task automatic ret();
        @(negedge clk) core_return = 1'b1;
        @(negedge clk) core_return = 1'b0;
    endtask : ret

    // Bounded wait for the next accept, then check its vector and level
    task automatic take(input logic [15:0] v, input logic h);
        int k;
        snap = n_acc;
        for (k = 0; k < 30 && n_acc == snap; k++) @(negedge clk);
        `CHK(n_acc, snap + 1)
        `CHK({last_high, last_vec}, {h, v})
        @(negedge clk);
    endtask : take

    // Nothing may be requested or accepted over a few cycles
    task automatic idle_chk();
        snap = n_acc;
        repeat (4) @(negedge clk);
        `CHK(irq_out.req, 1'b0)
        `CHK(n_acc, snap)
    endtask : idle_chk

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHK({priority_levels_enable, glob_en, irq_out, svc_state}, 23'h0)
        `CHK(src_flag, 48'h0)
        `CHK($bits(src_flag), `TLIC_CORE_SRC + `TLIC_GROUP_REGS * `TLIC_BITS_PER_REG)
        // Flag sets with every enable off; individual enable blocks
        ev(48'h8);
        `CHK(src_flag[3], 1'b1)
        gw(2'b10);
        idle_chk();
        clr(48'h8);
        `CHK(src_flag[3], 1'b0)
        // Compatibility mode, priority bits clear yet vector stays high
        src_enable = 48'h10a;
        ev(48'h2);
        take(16'h0008, 1'b1);
        `CHK(glob_en, 2'b00)
        `CHK(svc_state, TLIC_SV_HIGH)
        clr(48'h2);
        ret();
        `CHK(glob_en, 2'b10)
        // Peripheral source needs both enables, slow core answer
        acc_delay = 4'h3;
        ev(48'h100);
        idle_chk();
        gw(2'b01);
        idle_chk();
        gw(2'b11);
        take(16'h0008, 1'b1);
        clr(48'h100);
        ret();
        acc_delay = 4'h0;
        // Two-level mode: low source gated by both globals
        pw(1'b1);
        `CHK(priority_levels_enable, 1'b1)
        src_enable = 48'h205;
        src_priority = 48'h4;
        gw(2'b01);
        ev(48'h200);
        idle_chk();
        gw(2'b10);
        idle_chk();
        gw(2'b11);
        take(16'h0018, 1'b0);
        `CHK({glob_en, svc_state}, {2'b10, TLIC_SV_LOW})
        ev(48'h4);
        take(16'h0008, 1'b1);
        `CHK(svc_state, TLIC_SV_NEST)
        clr(48'h4);
        ret();
        `CHK({glob_en, svc_state}, {2'b10, TLIC_SV_LOW})
        clr(48'h200);
        ret();
        `CHK({glob_en, svc_state}, {2'b11, TLIC_SV_IDLE})
        // Simultaneous high and low: high first, low waits for its end
        acc_en = 1'b0;
        ev(48'h204);
        @(negedge clk);
        `CHK({irq_out.req, irq_out.high, irq_out.vector}, 18'h30008)
        acc_en = 1'b1;
        take(16'h0008, 1'b1);
        clr(48'h4);
        // Software reopens both levels, so only the service state holds low back
        gw(2'b11);
        idle_chk();
        ret();
        take(16'h0018, 1'b0);
        clr(48'h200);
        ret();
        // External pin edge, no priority bit yet always high
        @(negedge clk) ext_external_interrupt_zero_pin = 1'b1;
        take(16'h0008, 1'b1);
        `CHK(src_flag[0], 1'b1)
        clr(48'h1);
        ret();
        // Falling edge selected; the pin is high so no edge on the switch
        ext_external_interrupt_zero_rising = 1'b0;
        @(negedge clk) ext_external_interrupt_zero_pin = 1'b0;
        take(16'h0008, 1'b1);
        `CHK(src_flag[0], 1'b1)
        clr(48'h1);
        ret();
        // Mid-run reset drops back to compatibility mode
        @(negedge clk) rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHK({priority_levels_enable, glob_en, irq_out, svc_state}, 23'h0)
        // Low-priority source now vectors high, priority bit ignored
        gw(2'b11);
        ev(48'h200);
        take(16'h0008, 1'b1);
        give_verdict();
    end
endmodule : tb_tlic_ctrl

// file: tb/tlic_core_model.sv
// Behavioural model of the processor core facing the interrupt controller.
// Assumes irq_out is registered on clk; accepts are driven at the falling edge.
`timescale 1ns/1ns

module tlic_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire tlic_pkg::tlic_vec_s irq_out,
    input wire logic acc_en,
    input wire logic [3:0] acc_delay,
    output logic core_accept,
    output logic [15:0] last_vec,
    output logic last_high,
    output int n_acc
);
    import tlic_pkg::*;

    // ****************************************************************
    // Accept timing
    // ****************************************************************
    logic [3:0] wait_cnt; // Cycles the request has been seen

    // Accept is a one-cycle pulse; a gap follows so a withdrawn request is not taken twice
    // One process owns the pulse and its counter
    initial begin
        core_accept = 1'b0;
        wait_cnt = 4'h0;
        forever begin
            @(negedge clk);
            core_accept <= 1'b0;
            if (rst_n && acc_en && irq_out.req && !core_accept) begin
                if (wait_cnt >= acc_delay) begin
                    core_accept <= 1'b1;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end

    // Vector is taken at the edge where the accept is sampled
    initial begin
        last_vec = 16'h0000;
        last_high = 1'b0;
        n_acc = 0;
        forever begin
            @(posedge clk);
            if (core_accept && irq_out.req) begin
                last_vec <= irq_out.vector;
                last_high <= irq_out.high;
                n_acc <= n_acc + 1;
            end
        end
    end
endmodule : tlic_core_model
